// >>> logic/print_string.sv
// print string store and character streamer
`timescale 1ns/100ps
module print_string #(
  parameter int LEN = sp_action_pkg::STR_LEN
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  input  wire logic       wr_en_in,
  input  wire logic [4:0] wr_idx_in,
  input  wire logic [7:0] wr_char_in,
  input  wire logic [4:0] rd_idx_in,
  output logic      [7:0] rd_char_out,
  input  wire logic [4:0] len_in,
  input  wire logic       start_in,
  output logic      [7:0] char_out,
  output logic            valid_out,
  input  wire logic       ready_in,
  output logic            busy_out
);
  if (LEN < 1 || LEN > 31) begin : g_len_chk
    $error("print string length must be 1..31");
  end

  logic [7:0] str_q [LEN];
  logic [4:0] pos_q;
  logic [4:0] last_q;

  // ==========================================================
  // text store; codes with top bit set are field tokens
  // text store
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      for (int i = 0; i < LEN; i++) str_q[i] <= 8'h00;
    end else if (ce_in && wr_en_in && 32'(wr_idx_in) < LEN) begin
      str_q[wr_idx_in] <= wr_char_in;
    end
  end

  assign rd_char_out = (32'(rd_idx_in) < LEN) ? str_q[rd_idx_in] : 8'h00;

  // ==========================================================
  // streamer; start while busy is dropped
  // tokens passed on
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pos_q     <= 5'h00;
      last_q    <= 5'h00;
      valid_out <= 1'b0;
      busy_out  <= 1'b0;
      char_out  <= 8'h00;
    end else if (ce_in) begin
      if (!busy_out) begin
        if (start_in && len_in != 5'h00) begin
          busy_out  <= 1'b1;
          valid_out <= 1'b1;
          pos_q     <= 5'h00;
          last_q    <= len_in - 5'h01;
          char_out  <= str_q[0];
        end
      end else if (valid_out && ready_in) begin
        if (pos_q == last_q || 32'(pos_q) + 1 >= LEN) begin
          valid_out <= 1'b0;
          busy_out  <= 1'b0;
        end else begin
          pos_q    <= pos_q + 5'h01;
          char_out <= str_q[pos_q + 5'h01];
        end
      end
    end
  end

endmodule : print_string

// >>> logic/sp_action.sv
// setpoint reset, print and log action unit with register slave
`timescale 1ns/100ps
module sp_action #(
  parameter int LOG_DEPTH = sp_action_pkg::LOG_DEPTH
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // register bus
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // meter side
  input  wire logic        sample_tick_in,
  input  wire logic        relay_on_in,
  input  wire logic [31:0] input_value_in,
  input  wire logic [31:0] setpoint_value_in,
  output logic             mreg_rd_req_out,
  output logic [7:0]       mreg_rd_addr_out,
  input  wire logic [31:0] mreg_rd_data_in,
  input  wire logic        mreg_rd_valid_in,
  output sp_action_pkg::regwr_s mreg_wr_out,
  // pins and clock option
  input  wire logic        prog_button_in,
  input  wire logic        log_switch_in,
  input  wire logic        rtc_present_in,
  input  wire logic [31:0] rtc_stamp_in,
  // print and log units
  output logic [7:0]       print_char_out,
  output logic             print_valid_out,
  input  wire logic        print_ready_in,
  output logic             log_wr_out,
  output logic [15:0]      log_addr_out,
  output logic [31:0]      log_stamp_out,
  output logic             log_stamped_out,
  output logic             irq_out
);
  if (LOG_DEPTH <= 4000 || LOG_DEPTH * sp_action_pkg::LOG_REC_BYTES > 65536)
  begin : g_depth_chk
    $error("log depth must exceed 4000 and fit 64 kilobytes");
  end

  // ==========================================================
  // register state
  sp_action_pkg::ctrl_s ctrl_q;
  logic [31:0]          const_q;
  logic [7:0]           src_q;
  logic [2:0]           glb_q;
  logic [31:0]          intv_q;
  logic [sp_action_pkg::ST_W-1:0] st_q;
  logic [sp_action_pkg::ST_W-1:0] mask_q;
  logic [sp_action_pkg::ST_W-1:0] st_set;
  logic [4:0]           plen_q;
  logic [15:0]          log_ptr_q;

  // write-strobe merge used by the control, constant and interval registers
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : wmerge

  // ==========================================================
  // write channel
  logic        wr_go;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [31:0] cnew;
  logic        pstr_wr;
  logic        aw_take;

  assign aw_take = s_axi_awvalid_in && s_axi_wvalid_in && !s_axi_bvalid_out
                   && !s_axi_awready_out;
  assign wr_go = ce_in && s_axi_awvalid_in && s_axi_wvalid_in && s_axi_awready_out;
  assign wa = {s_axi_awaddr_in[7:2], 2'b00};
  assign wd = s_axi_wdata_in;
  assign cnew = wmerge(const_q, wd, s_axi_wstrb_in);
  assign pstr_wr = wr_go && wa >= sp_action_pkg::PSTR_OFS && s_axi_wstrb_in[0];

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= 2'b00;
    end else if (ce_in) begin
      s_axi_awready_out <= aw_take;
      s_axi_wready_out  <= aw_take;
      if (wr_go) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= (wa <= sp_action_pkg::PLEN_OFS
                             || wa >= sp_action_pkg::PSTR_OFS) ? 2'b00 : 2'b10;
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl_q <= sp_action_pkg::CTRL_RST;
      src_q  <= 8'h00;
      glb_q  <= 3'h0;
      intv_q <= sp_action_pkg::INTV_RST;
      mask_q <= '0;
      plen_q <= 5'h00;
    end else if (wr_go) begin
      case (wa)
        sp_action_pkg::CTRL_OFS:
          ctrl_q <= 17'(wmerge({15'h0, ctrl_q}, wd, s_axi_wstrb_in));
        sp_action_pkg::SRC_OFS: if (s_axi_wstrb_in[0]) src_q <= wd[7:0];
        sp_action_pkg::GLOBAL_OFS: if (s_axi_wstrb_in[0]) glb_q <= wd[2:0];
        sp_action_pkg::INTERVAL_OFS: intv_q <= wmerge(intv_q, wd, s_axi_wstrb_in);
        sp_action_pkg::MASK_OFS: if (s_axi_wstrb_in[0]) mask_q <= wd[3:0];
        sp_action_pkg::PLEN_OFS: if (s_axi_wstrb_in[0]) plen_q <= wd[4:0];
        default: ;
      endcase
    end
  end

  logic const_refused;
  assign const_refused = wr_go && wa == sp_action_pkg::CONST_OFS
                         && ($signed(cnew) < sp_action_pkg::CONST_MIN
                             || $signed(cnew) > sp_action_pkg::CONST_MAX);
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      const_q <= sp_action_pkg::CONST_RST;
    end else if (wr_go && wa == sp_action_pkg::CONST_OFS && ctrl_q.rmode != sp_action_pkg::rm_copy
                 && !const_refused) begin
      const_q <= cnew;
    end
  end

  // ==========================================================
  // read channel
  logic [31:0] rd_mux;
  logic [7:0]  ra;
  logic [7:0]  pchar;
  logic        ra_ok;
  assign ra = {s_axi_araddr_in[7:2], 2'b00};

  always_comb begin
    rd_mux = 32'h0000_0000;
    ra_ok  = 1'b1;
    case (ra)
      sp_action_pkg::CTRL_OFS:     rd_mux = {15'h0, ctrl_q};
      sp_action_pkg::CONST_OFS:
        rd_mux = (ctrl_q.rmode == sp_action_pkg::rm_copy) ? 32'h0000_0000 : const_q;
      sp_action_pkg::SRC_OFS:      rd_mux = {24'h0, src_q};
      sp_action_pkg::GLOBAL_OFS:   rd_mux = {29'h0, glb_q};
      sp_action_pkg::INTERVAL_OFS: rd_mux = intv_q;
      sp_action_pkg::STATUS_OFS:   rd_mux = {28'h0, st_q};
      sp_action_pkg::MASK_OFS:     rd_mux = {28'h0, mask_q};
      sp_action_pkg::LOGPTR_OFS:   rd_mux = {16'h0, log_ptr_q};
      sp_action_pkg::PLEN_OFS:     rd_mux = {27'h0, plen_q};
      default: begin
        if (ra >= sp_action_pkg::PSTR_OFS) rd_mux = {24'h0, pchar};
        else ra_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= 2'b00;
    end else if (ce_in) begin
      s_axi_arready_out <= s_axi_arvalid_in && !s_axi_rvalid_out && !s_axi_arready_out;
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rdata_out   <= rd_mux;
        s_axi_rresp_out   <= ra_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // pin synchronisers and edges
  logic [2:0] btn_q;
  logic [2:0] sw_q;
  logic       btn_rise;
  logic       sw_rise;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      btn_q <= 3'h0;
      sw_q  <= 3'h0;
    end else if (ce_in) begin
      btn_q <= {btn_q[1:0], prog_button_in};
      sw_q  <= {sw_q[1:0], log_switch_in};
    end
  end
  assign btn_rise = ce_in && btn_q[1] && !btn_q[2];
  assign sw_rise  = ce_in && sw_q[1] && !sw_q[2];

  // ==========================================================
  // trigger decode
  logic relay_prev_q;
  logic fire;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) relay_prev_q <= 1'b0;
    else if (ce_in && sample_tick_in) relay_prev_q <= relay_on_in;
  end

  always_comb begin
    case (ctrl_q.trig)
      sp_action_pkg::trig_make:  fire = relay_on_in && !relay_prev_q;
      sp_action_pkg::trig_break: fire = !relay_on_in && relay_prev_q;
      sp_action_pkg::trig_both:  fire = relay_on_in != relay_prev_q;
      default:                   fire = relay_on_in;
    endcase
    fire = fire && sample_tick_in && ce_in;
  end

  // ==========================================================
  // reset action engine
  typedef enum logic [1:0] {st_idle, st_read} eng_e;
  eng_e        eng_q;
  logic [31:0] overshoot;
  assign overshoot = input_value_in - setpoint_value_in + const_q;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      eng_q            <= st_idle;
      mreg_rd_req_out  <= 1'b0;
      mreg_rd_addr_out <= 8'h00;
      mreg_wr_out      <= '0;
    end else if (ce_in) begin
      mreg_wr_out.en <= 1'b0;
      case (eng_q)
        st_idle: begin
          if (fire && ctrl_q.destination_register != 8'h00) begin
            mreg_wr_out.addr <= ctrl_q.destination_register;
            case (ctrl_q.rmode)
              sp_action_pkg::rm_const: begin
                mreg_wr_out.en   <= 1'b1;
                mreg_wr_out.data <= const_q;
              end
              sp_action_pkg::rm_overshoot: begin
                mreg_wr_out.en   <= 1'b1;
                mreg_wr_out.data <= overshoot;
              end
              sp_action_pkg::rm_accum: begin
                mreg_rd_req_out  <= 1'b1;
                mreg_rd_addr_out <= ctrl_q.destination_register;
                eng_q            <= st_read;
              end
              default: begin
                mreg_rd_req_out  <= 1'b1;
                mreg_rd_addr_out <= src_q;
                eng_q            <= st_read;
              end
            endcase
          end
        end
        st_read: begin
          // single write, later triggers dropped while busy
          if (mreg_rd_valid_in) begin
            mreg_rd_req_out <= 1'b0;
            mreg_wr_out.en  <= 1'b1;
            mreg_wr_out.data <= (ctrl_q.rmode == sp_action_pkg::rm_accum)
                                ? mreg_rd_data_in + const_q : mreg_rd_data_in;
            eng_q <= st_idle;
          end
        end
        default: eng_q <= st_idle;
      endcase
    end
  end

  // ==========================================================
  // print requests
  logic [31:0] intv_cnt_q;
  logic        intv_hit;
  logic        print_go;
  logic        print_busy;
  assign intv_hit = glb_q[sp_action_pkg::GLB_INTV_BIT] && intv_q != 32'h0
                    && sample_tick_in && ce_in && intv_cnt_q + 32'h1 >= intv_q;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) intv_cnt_q <= 32'h0000_0000;
    else if (ce_in && sample_tick_in) intv_cnt_q <= intv_hit ? 32'h0 : intv_cnt_q + 32'h1;
  end

  // print gated by serial print mode
  assign print_go = glb_q[sp_action_pkg::GLB_PRINT_BIT]
                    && ((fire && ctrl_q.print_en) || intv_hit || btn_rise);

  print_string #(
    .LEN (sp_action_pkg::STR_LEN)
  ) u_print (
    .clk_sys_in  (clk_sys_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .wr_en_in    (pstr_wr),
    .wr_idx_in   (wa[6:2]),
    .wr_char_in  (wd[7:0]),
    .rd_idx_in   (ra[6:2]),
    .rd_char_out (pchar),
    .len_in      (plen_q),
    .start_in    (print_go),
    .char_out    (print_char_out),
    .valid_out   (print_valid_out),
    .ready_in    (print_ready_in),
    .busy_out    (print_busy)
  );

  // ==========================================================
  // log requests into loop buffer
  logic log_go;
  assign log_go = glb_q[sp_action_pkg::GLB_LOG_BIT]
                  && ((fire && ctrl_q.log_en) || btn_rise || sw_rise);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      log_ptr_q       <= 16'h0000;
      log_wr_out      <= 1'b0;
      log_addr_out    <= 16'h0000;
      log_stamp_out   <= 32'h0000_0000;
      log_stamped_out <= 1'b0;
    end else if (ce_in) begin
      log_wr_out <= log_go;
      if (log_go) begin
        log_addr_out    <= log_ptr_q;
        log_ptr_q       <= (32'(log_ptr_q) + 1 >= LOG_DEPTH) ? 16'h0000
                           : log_ptr_q + 16'h0001;
        log_stamped_out <= rtc_present_in;
        log_stamp_out   <= rtc_present_in ? rtc_stamp_in : 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // sticky status, set beats write-one-clear
  assign st_set = {const_refused, log_go, print_go && !print_busy,
                   mreg_wr_out.en && ce_in};
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_q    <= '0;
      irq_out <= 1'b0;
    end else if (ce_in) begin
      st_q <= (st_q & ~((wr_go && wa == sp_action_pkg::STATUS_OFS && s_axi_wstrb_in[0])
                        ? wd[3:0] : 4'h0)) | st_set;
      irq_out <= |(st_q & mask_q);
    end
  end

endmodule : sp_action

// >>> logic/sp_action_pkg.sv
// constants, types and register map of the setpoint action unit
package sp_action_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] CONST_OFS    = 8'h04;
  localparam logic [7:0] SRC_OFS      = 8'h08;
  localparam logic [7:0] GLOBAL_OFS   = 8'h0C;
  localparam logic [7:0] INTERVAL_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS   = 8'h14;
  localparam logic [7:0] MASK_OFS     = 8'h18;
  localparam logic [7:0] LOGPTR_OFS   = 8'h1C;
  localparam logic [7:0] PLEN_OFS     = 8'h20;
  localparam logic [7:0] PSTR_OFS     = 8'h80;

  // ==========================================================
  // field positions and reset values
  localparam int GLB_PRINT_BIT = 0;
  localparam int GLB_LOG_BIT   = 1;
  localparam int GLB_INTV_BIT  = 2;
  localparam int ST_RESET_BIT  = 0;
  localparam int ST_PRINT_BIT  = 1;
  localparam int ST_LOG_BIT    = 2;
  localparam int ST_REFUSE_BIT = 3;
  localparam int ST_W          = 4;
  localparam logic signed [31:0] CONST_MIN = -32'sd19999;
  localparam logic signed [31:0] CONST_MAX = 32'sd99999;
  localparam logic [31:0] CONST_RST = 32'h0000_0000;
  localparam logic [31:0] INTV_RST  = 32'h0000_0000;
  localparam int STR_LEN   = 31;
  localparam int LOG_DEPTH = 4096;
  // 64 kilobytes over 16-byte records
  localparam int LOG_REC_BYTES = 16;

  // ==========================================================
  // types
  typedef enum logic [1:0] {trig_make, trig_break, trig_both, trig_level} trig_e;
  typedef enum logic [1:0] {rm_const, rm_overshoot, rm_accum, rm_copy} rmode_e;

  typedef struct packed {
    logic [2:0] menu_digit;
    logic       log_en;
    logic       print_en;
    logic [7:0] destination_register;
    rmode_e     rmode;
    trig_e      trig;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '{3'h0, 1'b0, 1'b0, 8'h00, rm_const, trig_make};

  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [31:0] data;
  } regwr_s;

endpackage : sp_action_pkg

// >>> test/meter_model.sv
// meter register file and printer partner model
`timescale 1ns/100ps
module meter_model (
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_in,
  input  wire logic                  rd_req_in,
  input  wire logic [7:0]            rd_addr_in,
  output logic      [31:0]           rd_data_out,
  output logic                       rd_valid_out,
  input  wire sp_action_pkg::regwr_s wr_in,
  output logic                       ready_out
);
  logic [31:0] mem_q [256];
  logic [1:0]  wait_q = 2'h0;
  logic        done_q = 1'h0;
  initial begin
    rd_data_out = '0;
    rd_valid_out = 1'h0;
    ready_out = 1'h0;
    for (int i = 0; i < 256; i++) mem_q[i] = {8'h00, i[7:0], 16'h0007};
  end
  // answer latency walks 1..4 cycles; printer stalls one cycle in four
  always @(posedge clk_sys_in) begin
    wait_q <= wait_q + 2'h1;
    rd_valid_out <= 1'h0;
    ready_out <= wait_q != 2'h0;
    if (rst_in || !rd_req_in) begin
      done_q <= 1'h0;
      rd_data_out <= ~rd_data_out;
    end else if (!done_q && wait_q == 2'h3) begin
      rd_valid_out <= 1'h1;
      rd_data_out <= mem_q[rd_addr_in];
      done_q <= 1'h1;
    end else begin
      rd_data_out <= ~rd_data_out;
    end
    if (wr_in.en) mem_q[wr_in.addr] <= wr_in.data;
  end
endmodule : meter_model

// >>> test/sp_action_properties.sv
// port-level checks of the setpoint action unit
`timescale 1ns/100ps
module sp_action_properties (
  input wire logic                  clk_sys_in,
  input wire logic                  rst_in,
  input wire logic                  sample_tick_in,
  input wire logic                  mreg_rd_req_out,
  input wire logic [7:0]            mreg_rd_addr_out,
  input wire logic                  mreg_rd_valid_in,
  input wire sp_action_pkg::regwr_s mreg_wr_out,
  input wire logic                  rtc_present_in,
  input wire logic [7:0]            print_char_out,
  input wire logic                  print_valid_out,
  input wire logic                  print_ready_in,
  input wire logic                  log_wr_out,
  input wire logic                  log_stamped_out
);
  // ==========
  // assertions
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  a_wr_one_pulse: assert property (mreg_wr_out.en |=> !mreg_wr_out.en)
    else $error("reset write longer than one cycle");
  a_wr_has_cause: assert property (
    mreg_wr_out.en |-> $past(sample_tick_in) || $past(mreg_rd_valid_in))
    else $error("reset write without trigger or read answer");
  a_wr_destination_register_on: assert property (mreg_wr_out.en |-> mreg_wr_out.addr != 8'h00)
    else $error("reset write to destination off");
  a_rd_then_wr: assert property (
    mreg_rd_req_out && mreg_rd_valid_in |=> mreg_wr_out.en && !mreg_rd_req_out)
    else $error("read answer not followed by write");
  a_rd_held: assert property (
    mreg_rd_req_out && !mreg_rd_valid_in |=> mreg_rd_req_out && $stable(mreg_rd_addr_out))
    else $error("register read request dropped or moved");
  a_rd_from_tick: assert property ($rose(mreg_rd_req_out) |-> $past(sample_tick_in))
    else $error("register read without sample tick");
  a_print_held: assert property (
    print_valid_out && !print_ready_in |=> print_valid_out && $stable(print_char_out))
    else $error("print character not held");
  a_log_stamp: assert property (
    log_wr_out |-> log_stamped_out == $past(rtc_present_in))
    else $error("log stamp flag wrong");
endmodule : sp_action_properties

bind sp_action sp_action_properties i_props (.*);

// >>> test/tb_sp_action.sv
// self-checking bench of the setpoint action unit
`timescale 1ns/100ps
module tb_sp_action;
  // ==========
  // signals
  logic clk_sys_in = 1'h0, rst_in = 1'h1, ce_in = 1'h1, s_axi_bready_in = 1'h1;
  logic s_axi_rready_in = 1'h1, s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0;
  logic s_axi_arvalid_in = 1'h0, sample_tick_in = 1'h0, relay_on_in = 1'h0;
  logic prog_button_in = 1'h0, log_switch_in = 1'h0, rtc_present_in = 1'h0;
  logic [7:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0, mreg_rd_addr_out, print_char_out;
  logic [31:0] s_axi_wdata_in = '0, input_value_in = '0, setpoint_value_in = '0;
  logic [31:0] rtc_stamp_in = '0, s_axi_rdata_out, mreg_rd_data_in, log_stamp_out;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, mreg_rd_req_out, mreg_rd_valid_in, print_valid_out;
  logic print_ready_in, log_wr_out, log_stamped_out, irq_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, resp, glb, tg, md;
  logic [15:0] log_addr_out;
  sp_action_pkg::regwr_s mreg_wr_out;
  logic [31:0] seed = 32'h3589_9DDE, c, ctl, st, rd, last_wr, last_ch;
  logic [7:0] dst;
  logic [3:0] msk;
  logic pe, le;
  int errors = 0, num_checks = 0, nwr = 0, nlog = 0, l0, n;

  sp_action i_dut (.*);
  meter_model i_meter (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .rd_req_in(mreg_rd_req_out),
    .rd_addr_in(mreg_rd_addr_out), .rd_data_out(mreg_rd_data_in),
    .rd_valid_out(mreg_rd_valid_in), .wr_in(mreg_wr_out), .ready_out(print_ready_in));

  always #12.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    if (mreg_wr_out.en === 1'h1) begin
      nwr++;
      last_wr = mreg_wr_out.data;
    end
    if (log_wr_out === 1'h1) begin
      chk(log_addr_out, nlog);
      chk(log_stamp_out, rtc_present_in ? rtc_stamp_in : 32'h0);
      nlog++;
    end
    if (print_valid_out === 1'h1) last_ch = {24'h0, print_char_out};
  end

  // ==========
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] mval(input logic [7:0] i);
    return {8'h00, i, 16'h0007};
  endfunction : mval
  // level and both-edge cases fire twice over the relay pattern
  function automatic logic [31:0] exp_wr(input logic [1:0] m, input logic [31:0] k);
    case (m)
      2'h0: return k;
      2'h1: return input_value_in - setpoint_value_in + k;
      2'h2: return mval(dst) + k + k;
      default: return mval(8'hC8);
    endcase
  endfunction : exp_wr
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    do @(posedge clk_sys_in); while (s_axi_awready_out !== 1'h1);
    s_axi_awvalid_in <= 1'h0;
    s_axi_wvalid_in <= 1'h0;
    while (s_axi_bvalid_out !== 1'h1) @(posedge clk_sys_in);
    resp = s_axi_bresp_out;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge clk_sys_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'h1;
    do @(posedge clk_sys_in); while (s_axi_arready_out !== 1'h1);
    s_axi_arvalid_in <= 1'h0;
    while (s_axi_rvalid_out !== 1'h1) @(posedge clk_sys_in);
    rd = s_axi_rdata_out;
    resp = s_axi_rresp_out;
  endtask : axr
  task automatic tick(input logic r);
    @(posedge clk_sys_in);
    relay_on_in <= r;
    sample_tick_in <= 1'h1;
    @(posedge clk_sys_in);
    sample_tick_in <= 1'h0;
    repeat (9) @(posedge clk_sys_in);
  endtask : tick
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // ==========
  // tests
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    errors++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    axr(sp_action_pkg::CONST_OFS);
    chk(rd, sp_action_pkg::CONST_RST);
    axw(sp_action_pkg::CONST_OFS, 32'h0001_86A0);
    axr(sp_action_pkg::CONST_OFS);
    chk(rd, sp_action_pkg::CONST_RST);
    axr(sp_action_pkg::STATUS_OFS);
    chk(rd, 32'h1 << sp_action_pkg::ST_REFUSE_BIT);
    axw(sp_action_pkg::CONST_OFS, 32'hFFFF_B1E1);
    axr(sp_action_pkg::CONST_OFS);
    chk(rd, 32'hFFFF_B1E1);
    axr(8'h40);
    chk(resp, 2'h2);
    axw(sp_action_pkg::STATUS_OFS, 32'hF);
    axw(sp_action_pkg::PSTR_OFS, 32'h41);
    axw(sp_action_pkg::PLEN_OFS, 32'h1);
    axw(sp_action_pkg::SRC_OFS, 32'hC8);
    for (int t = 0; t < 5; t++) begin
      seed = lfsr(seed);
      c = seed % 32'h0001_D4BF - 32'h0000_4E1F;
      {le, pe, msk, glb} = seed[7:0];
      input_value_in <= seed;
      rtc_stamp_in <= seed;
      seed = lfsr(seed);
      setpoint_value_in <= seed;
      rtc_present_in <= t[0];
      dst = (t == 4) ? 8'h00 : 8'h0A + t[7:0];
      tg = (t == 4) ? 2'h3 : t[1:0];
      md = (t == 4) ? 2'h0 : t[1:0];
      n = (tg >= 2'h2) ? 2 : 1;
      ctl = {18'h0, le, pe, dst, md, tg};
      axw(sp_action_pkg::GLOBAL_OFS, {30'h0, glb});
      axw(sp_action_pkg::MASK_OFS, {28'h0, msk});
      axw(sp_action_pkg::CTRL_OFS, ctl | 32'h0001_C000);
      axw(sp_action_pkg::CTRL_OFS, ctl);
      axw(sp_action_pkg::CONST_OFS, c);
      if (t == 3) axr(sp_action_pkg::CONST_OFS);
      if (t == 3) chk(rd, 32'h0);
      nwr = 0;
      l0 = nlog;
      for (int i = 0; i < 5; i++) tick(i == 1 || i == 2);
      chk(nwr, (dst != 8'h00) ? n : 0);
      if (dst != 8'h00) chk(last_wr, exp_wr(md, c));
      chk(nlog - l0, (le && glb[1]) ? n : 0);
      if (pe && glb[0]) chk(last_ch, 32'h41);
      st = {29'h0, le & glb[1], pe & glb[0], dst != 8'h00};
      axr(sp_action_pkg::STATUS_OFS);
      chk(rd, st);
      chk(irq_out, |(st[3:0] & msk));
      axw(sp_action_pkg::STATUS_OFS, 32'hF);
      repeat (3) @(posedge clk_sys_in);
      chk(irq_out, 1'h0);
      $display("test %0d done", t);
    end
    axw(sp_action_pkg::GLOBAL_OFS, 32'h3);
    for (int i = 0; i < 2; i++) begin
      l0 = nlog;
      {log_switch_in, prog_button_in} <= 2'h1 << i;
      repeat (4) @(posedge clk_sys_in);
      {log_switch_in, prog_button_in} <= 2'h0;
      repeat (10) @(posedge clk_sys_in);
      chk(nlog - l0, 1);
    end
    axr(sp_action_pkg::LOGPTR_OFS);
    chk(rd, nlog);
    $display("pin log test done");
    axw(sp_action_pkg::GLOBAL_OFS, 32'h5);
    axw(sp_action_pkg::INTERVAL_OFS, 32'h2);
    axw(sp_action_pkg::STATUS_OFS, 32'hF);
    repeat (3) tick(1'h0);
    axr(sp_action_pkg::STATUS_OFS);
    chk(rd[sp_action_pkg::ST_PRINT_BIT], 1'h1);
    $display("interval print test done");
    close_out();
  end
endmodule : tb_sp_action
